/* core_peripheral_model.sv */
// Model of the processor core and the peripheral sources facing the controller.
`timescale 1ns/1ps

module core_peripheral_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Settings from the bench
  input wire logic [3:0] ackDelay,
  input wire logic [17:0] reqIn,
  input wire logic [17:0] enIn,
  // Controller side
  input wire logic intRequest,
  output logic [17:0] srcRequest,
  output logic [17:0] srcEnable,
  output logic intAck
);
  logic [3:0] waitCnt;
  logic served;

  assign srcRequest = reqIn;
  assign srcEnable = enIn;

  // The request only falls a cycle after the acknowledge, so a taken request is not taken again.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
      intAck <= 1'b0;
      served <= 1'b0;
    end else if (intAck || served || !intRequest || ackDelay == 4'h0) begin
      waitCnt <= 4'h0;
      intAck <= 1'b0;
      served <= (served || intAck) && intRequest;
    end else if (waitCnt + 4'h1 >= ackDelay) begin
      intAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule // core_peripheral_model

/* interrupt_level_control.sv */
// Interrupt level controller: mask, priority, request and system mode registers and arbiter.
//
// Function
// - Same level: lowest vector address wins, fixed.
// - Priority index zero is highest within level.
// - Global enable is bit 0; instructions set/clear.
// - Enabled interrupts serviced by configured priority.
// - Read/write mask register, one bit per level.
// - Priority groups: A 0-1, B 2-4, C 5-7.
// - Read-only request register, one bit per level.
// - System mode holds fast-interrupt and external-interface controls.
// - Direct write of bit 0 changes global enable.
// - Service needs global, level and source enables.
// - Each source has its own peripheral enable.
// - Priority bits 7,4,1 select group order.
// - Mask bit n enables level n when one.
// - Reset clears system mode bits 0 and 1.
// - Acknowledge clears global enable; return sets it.
`timescale 1ns/1ps
`include "interrupt_level_control_regs.svh"

module interrupt_level_control
  import interrupt_level_control_pkg::*;
#(
  parameter int NUM_SOURCES = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Core instruction strobes
  input wire logic enableInterruptInstruction,
  input wire logic disableInterruptInstruction,
  input wire logic interruptReturnInstruction,
  input wire logic intAck,
  // Peripheral sources, index in vector address order
  input wire logic [NUM_SOURCES-1:0] srcRequest,
  input wire logic [NUM_SOURCES-1:0] srcEnable,
  // Towards the core
  output logic intRequest,
  output level_t winLevel,
  output logic [4:0] winSource,
  output logic [7:0] winVector,
  output logic inService,
  output logic [7:0] levelRequest
);

  // The source-to-level map is written out by hand, so only eighteen sources fit it.
  if (NUM_SOURCES != 18) begin : g_bad_source_count
    $error("interrupt_level_control: the level map serves exactly 18 sources");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Level owning each source; the vector order puts sources of one level next to each other.
  function automatic level_t srcLevel(input int idx);
    if (idx < 2) return 3'h0;
    else if (idx == 2) return 3'h1;
    else if (idx == 3) return 3'h2;
    else if (idx < 6) return 3'h3;
    else if (idx == 6) return 3'h4;
    else if (idx < 10) return 3'h5;
    else if (idx < 14) return 3'h6;
    else return 3'h7;
  endfunction

  function automatic logic [7:0] vectorOf(input logic [4:0] idx);
    return `VECTOR_BASE + 8'(idx) * 8'(`VECTOR_STEP);
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  // Only the second flop is read, so a release near an edge never reaches the registers.
  logic rstMeta;
  logic rstSync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync_n <= rstMeta;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic globalEnable;
  logic [7:1] systemMode;
  logic [7:0] levelMask;
  logic [7:0] levelPriority;
  logic modeWrite;

  assign modeWrite = regWrite && (regAddr == `SYSTEM_MODE_ADDR);

  // An acknowledge always wins so a granted interrupt can never re-enter itself.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      globalEnable <= 1'b0;
    end else if (intAck) begin
      globalEnable <= 1'b0;
    end else if (disableInterruptInstruction) begin
      globalEnable <= 1'b0;
    end else if (enableInterruptInstruction || interruptReturnInstruction) begin
      globalEnable <= 1'b1;
    end else if (modeWrite) begin
      globalEnable <= regWdata[`MODE_GLOBAL_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      systemMode <= 7'(`SYSTEM_MODE_RESET >> 1);
    end else if (modeWrite) begin
      systemMode <= regWdata[7:1];
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      levelMask <= `LEVEL_MASK_RESET;
    end else if (regWrite && regAddr == `LEVEL_MASK_ADDR) begin
      levelMask <= regWdata;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      levelPriority <= `LEVEL_PRIORITY_RESET;
    end else if (regWrite && regAddr == `LEVEL_PRIORITY_ADDR) begin
      levelPriority <= regWdata;
    end
  end

  // ****************************************
  // Per-level request and eligibility
  // ****************************************
  logic [7:0] rawLevel;
  logic [7:0] eligibleLevel;
  logic [NUM_SOURCES-1:0] eligibleSrc;

  always_comb begin
    rawLevel = 8'h00;
    eligibleLevel = 8'h00;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      eligibleSrc[i] = srcRequest[i] && srcEnable[i];
      rawLevel[srcLevel(i)] = rawLevel[srcLevel(i)] | srcRequest[i];
      eligibleLevel[srcLevel(i)] = eligibleLevel[srcLevel(i)] | eligibleSrc[i];
    end
    eligibleLevel = eligibleLevel & levelMask & {8{globalEnable}};
  end

  // Pending flags are visible even while interrupts are globally off.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      levelRequest <= 8'h00;
    end else begin
      levelRequest <= rawLevel;
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************
  logic levelFound;
  level_t bestLevel;
  logic [4:0] bestSource;

  level_priority_resolve resolver (
    .eligible(eligibleLevel),
    .orderBits(levelPriority),
    .found(levelFound),
    .winner(bestLevel)
  );

  always_comb begin
    bestSource = 5'h00;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (eligibleSrc[i] && srcLevel(i) == bestLevel) begin
        bestSource = 5'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      intRequest <= 1'b0;
      winLevel <= 3'h0;
      winSource <= 5'h00;
      winVector <= `VECTOR_BASE;
    end else begin
      intRequest <= levelFound && !intAck;
      winLevel <= bestLevel;
      winSource <= bestSource;
      winVector <= vectorOf(bestSource);
    end
  end

  // ****************************************
  // Service tracking
  // ****************************************
  service_state_e svcState;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      svcState <= SVC_IDLE;
    end else begin
      case (svcState)
        SVC_IDLE: if (intAck) svcState <= SVC_ACTIVE;
        SVC_ACTIVE: if (interruptReturnInstruction) svcState <= SVC_IDLE;
        default: svcState <= SVC_IDLE;
      endcase
    end
  end

  assign inService = (svcState == SVC_ACTIVE);

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `LEVEL_REQUEST_ADDR: regRdata <= levelRequest;
        `LEVEL_MASK_ADDR: regRdata <= levelMask;
        `SYSTEM_MODE_ADDR: regRdata <= {systemMode, globalEnable};
        `LEVEL_PRIORITY_ADDR: regRdata <= levelPriority;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [NUM_SOURCES-1:0] lastEligible;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lastEligible <= '0;
    end else begin
      lastEligible <= eligibleSrc;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  a_ack_clears_enable: assert property (intAck |=> !globalEnable && inService)
    else $error("acknowledge did not clear global enable");
  a_return_sets_enable: assert property (
    interruptReturnInstruction && !intAck && !disableInterruptInstruction |=> globalEnable)
    else $error("interrupt return did not set global enable");
  a_disable_clears_enable: assert property (
    disableInterruptInstruction |=> !globalEnable)
    else $error("disable instruction left global enable set");
  a_enable_sets_enable: assert property (
    enableInterruptInstruction && !intAck && !disableInterruptInstruction |=> globalEnable)
    else $error("enable instruction did not set global enable");
  a_write_sets_enable: assert property (
    modeWrite && regWdata[0] && !intAck && !disableInterruptInstruction
    |=> globalEnable && systemMode[1] == $past(regWdata[1]))
    else $error("system mode write not applied");
  a_no_request_off: assert property (!globalEnable |=> !intRequest)
    else $error("request raised with interrupts globally disabled");
  a_masked_level: assert property (intRequest |-> $past(levelMask[bestLevel]) == 1'b1)
    else $error("request raised for masked level");
  a_source_enabled: assert property (intRequest |-> lastEligible[winSource])
    else $error("winning source was not enabled and pending");
  a_request_mirror: assert property (srcRequest[0] |=> levelRequest[0])
    else $error("level request bit did not follow source");
  a_vector_match: assert property (intRequest |-> winVector == vectorOf(winSource))
    else $error("vector does not match winning source");
  a_mask_write: assert property (
    regWrite && regAddr == `LEVEL_MASK_ADDR |=> levelMask == $past(regWdata))
    else $error("level mask write not applied");
  a_priority_write: assert property (
    regWrite && regAddr == `LEVEL_PRIORITY_ADDR |=> levelPriority == $past(regWdata))
    else $error("level priority write not applied");
  a_return_ends_service: assert property (
    interruptReturnInstruction && !intAck |=> !inService)
    else $error("interrupt return did not end service");

  c_grant: cover property (intRequest ##1 intAck);
  c_return: cover property (inService ##[1:20] interruptReturnInstruction);
  c_two_levels: cover property (intRequest && $countones(levelRequest) > 1);
  c_top_level_first: cover property (intRequest && winLevel == 3'h7 && levelRequest[0]);

endmodule // interrupt_level_control

/* interrupt_level_control_pkg.sv */
// Shared types of the interrupt level controller.
package interrupt_level_control_pkg;

  typedef enum logic {
    SVC_IDLE,
    SVC_ACTIVE
  } service_state_e;

  typedef logic [2:0] level_t;

endpackage

/* interrupt_level_control_regs.svh */
// Register locations, field positions and reset values of the interrupt level controller.
`ifndef INTERRUPT_LEVEL_CONTROL_REGS_SVH
`define INTERRUPT_LEVEL_CONTROL_REGS_SVH

// ****************************************
// Register locations
// ****************************************
`define LEVEL_REQUEST_ADDR 8'hDC
`define LEVEL_MASK_ADDR 8'hDD
`define SYSTEM_MODE_ADDR 8'hDE
`define LEVEL_PRIORITY_ADDR 8'hFF

// ****************************************
// System mode fields
// ****************************************
`define MODE_GLOBAL_ENABLE_BIT 0
`define MODE_FAST_ENABLE_BIT 1
`define MODE_FAST_LEVEL_LSB 2
`define MODE_FAST_LEVEL_MSB 4
`define MODE_EXT_IF_LSB 5
`define MODE_EXT_IF_MSB 7

// ****************************************
// Priority fields
// ****************************************
`define PRIO_GROUP_HI_BIT 7
`define PRIO_GROUP_MID_BIT 4
`define PRIO_GROUP_LO_BIT 1
`define PRIO_A_ORDER_BIT 0
`define PRIO_B_SPLIT_BIT 2
`define PRIO_B_SUB_BIT 3
`define PRIO_C_SPLIT_BIT 5
`define PRIO_C_SUB_BIT 6

// ****************************************
// Reset values and vector layout
// ****************************************
`define SYSTEM_MODE_RESET 8'h00
`define LEVEL_MASK_RESET 8'h00
`define LEVEL_PRIORITY_RESET 8'h00
`define VECTOR_BASE 8'hDC
`define VECTOR_STEP 2

`endif

/* level_priority_resolve.sv */
// Picks the winning interrupt level from the programmed group and subgroup order.
`timescale 1ns/1ps
`include "interrupt_level_control_regs.svh"

module level_priority_resolve
  import interrupt_level_control_pkg::*;
(
  // Inputs
  input wire logic [7:0] eligible,
  input wire logic [7:0] orderBits,
  // Result
  output logic found,
  output level_t winner
);

  // ****************************************
  // Ranking
  // ****************************************
  level_t groupA [2];
  level_t groupB [3];
  level_t groupC [3];
  level_t rank [8];
  logic [2:0] groupSel;

  always_comb begin
    groupA[0] = orderBits[`PRIO_A_ORDER_BIT] ? 3'h1 : 3'h0;
    groupA[1] = orderBits[`PRIO_A_ORDER_BIT] ? 3'h0 : 3'h1;
    if (orderBits[`PRIO_B_SPLIT_BIT]) begin
      groupB[0] = orderBits[`PRIO_B_SUB_BIT] ? 3'h4 : 3'h3;
      groupB[1] = orderBits[`PRIO_B_SUB_BIT] ? 3'h3 : 3'h4;
      groupB[2] = 3'h2;
    end else begin
      groupB[0] = 3'h2;
      groupB[1] = orderBits[`PRIO_B_SUB_BIT] ? 3'h4 : 3'h3;
      groupB[2] = orderBits[`PRIO_B_SUB_BIT] ? 3'h3 : 3'h4;
    end
    if (orderBits[`PRIO_C_SPLIT_BIT]) begin
      groupC[0] = orderBits[`PRIO_C_SUB_BIT] ? 3'h7 : 3'h6;
      groupC[1] = orderBits[`PRIO_C_SUB_BIT] ? 3'h6 : 3'h7;
      groupC[2] = 3'h5;
    end else begin
      groupC[0] = 3'h5;
      groupC[1] = orderBits[`PRIO_C_SUB_BIT] ? 3'h7 : 3'h6;
      groupC[2] = orderBits[`PRIO_C_SUB_BIT] ? 3'h6 : 3'h7;
    end
    groupSel = {orderBits[`PRIO_GROUP_HI_BIT], orderBits[`PRIO_GROUP_MID_BIT],
                orderBits[`PRIO_GROUP_LO_BIT]};
    // The two unassigned settings fall back to A, B, C so the order is never empty.
    case (groupSel)
      3'h1: rank = '{groupB[0], groupB[1], groupB[2], groupC[0], groupC[1], groupC[2],
                     groupA[0], groupA[1]};
      3'h3: rank = '{groupB[0], groupB[1], groupB[2], groupA[0], groupA[1],
                     groupC[0], groupC[1], groupC[2]};
      3'h4: rank = '{groupC[0], groupC[1], groupC[2], groupA[0], groupA[1],
                     groupB[0], groupB[1], groupB[2]};
      3'h5: rank = '{groupC[0], groupC[1], groupC[2], groupB[0], groupB[1], groupB[2],
                     groupA[0], groupA[1]};
      3'h6: rank = '{groupA[0], groupA[1], groupC[0], groupC[1], groupC[2],
                     groupB[0], groupB[1], groupB[2]};
      default: rank = '{groupA[0], groupA[1], groupB[0], groupB[1], groupB[2],
                        groupC[0], groupC[1], groupC[2]};
    endcase
  end

  // ****************************************
  // First eligible level in rank order
  // ****************************************
  always_comb begin
    found = 1'b0;
    winner = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (eligible[rank[i]]) begin
        found = 1'b1;
        winner = rank[i];
      end
    end
  end

endmodule // level_priority_resolve

/* tb.sv */
// Self-checking bench of the interrupt level controller against a reference model.
`timescale 1ns/1ps

module tb;
  import interrupt_level_control_pkg::*;
  logic clk, rst_n, regWrite, regRead, en, dis, ret, intAck, intRequest, inService, ge;
  logic [7:0] regAddr, regWdata, regRdata, winVector, levelRequest, mask, prio, modeVal, d;
  level_t winLevel;
  logic [4:0] winSource;
  logic [17:0] srcRequest, srcEnable, reqIn, enIn;
  logic [3:0] ackDelay;
  logic [31:0] seed = 32'h000108F5;
  int errors, numChecks, n, w;
  int lv[18] = '{0, 0, 1, 2, 3, 3, 4, 5, 5, 5, 6, 6, 6, 6, 7, 7, 7, 7};
  logic [11:0] gOrd[8] = '{12'h012, 12'h120, 12'h012, 12'h102, 12'h201, 12'h210, 12'h021, 12'h012};

  interrupt_level_control #(.NUM_SOURCES(18)) i_interrupt_level_control (.clk(clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .enableInterruptInstruction(en),
    .disableInterruptInstruction(dis), .interruptReturnInstruction(ret), .intAck(intAck),
    .srcRequest(srcRequest), .srcEnable(srcEnable), .intRequest(intRequest),
    .winLevel(winLevel), .winSource(winSource), .winVector(winVector),
    .inService(inService), .levelRequest(levelRequest));

  core_peripheral_model i_core_peripheral_model (.clk(clk), .rst_n(rst_n),
    .ackDelay(ackDelay), .reqIn(reqIn), .enIn(enIn), .intRequest(intRequest),
    .srcRequest(srcRequest), .srcEnable(srcEnable), .intAck(intAck));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Reference model and checks
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [17:0] legal(input logic [17:0] e);
    legal = e;
    legal[1] = e[1] & !e[0];
    legal[5] = e[5] & !e[4];
  endfunction

  // Ranks all eight levels first, then takes the lowest source of the best eligible level.
  function automatic int expWin();
    int ord[$];
    int g, b;
    logic s, t;
    for (int k = 0; k < 3; k++) begin
      g = int'(gOrd[{prio[7], prio[4], prio[1]}] >> (8 - 4 * k)) & 3;
      if (g == 0) begin
        ord.push_back(int'(prio[0]));
        ord.push_back(int'(!prio[0]));
      end else begin
        b = (g == 1) ? 2 : 5;
        t = (g == 1) ? prio[2] : prio[5];
        s = (g == 1) ? prio[3] : prio[6];
        if (!t) ord.push_back(b);
        ord.push_back(b + 1 + int'(s));
        ord.push_back(b + 2 - int'(s));
        if (t) ord.push_back(b);
      end
    end
    foreach (ord[j]) begin
      for (int i = 0; i < 18; i++) begin
        if (ge && mask[ord[j]] && reqIn[i] && enIn[i] && lv[i] == ord[j]) return i;
      end
    end
    return -1;
  endfunction

  task automatic fail(input string msg);
    errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    numChecks++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
  endtask

  task automatic settle();
    logic [7:0] lr;
    repeat (3) @(posedge clk);
    #1;
    lr = 8'h00;
    for (int i = 0; i < 18; i++) lr[lv[i]] |= reqIn[i];
    w = expWin();
    chk(levelRequest, lr, "levels");
    chk({7'h00, intRequest}, {7'h00, w >= 0}, "pending");
    if (w >= 0) begin
      chk({5'h00, winLevel}, 8'(lv[w]), "level");
      chk({3'h0, winSource}, 8'(w), "source");
      chk(winVector, 8'hDC + 8'(2 * w), "vector");
    end
  endtask

  // ****************************************
  // Drivers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    v = regRdata;
  endtask

  task automatic instr(input int k);
    @(posedge clk);
    en <= (k == 0);
    dis <= (k == 1);
    ret <= (k == 2);
    @(posedge clk);
    en <= 1'b0;
    dis <= 1'b0;
    ret <= 1'b0;
    ge = (k != 1);
  endtask

  // Interrupts go off before every mask change, as software is obliged to do.
  task automatic setMask(input logic [7:0] m);
    instr(1);
    wr(8'hDD, m);
    mask = m;
  endtask

  task automatic conclude();
    if (errors == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail("timeout");
    conclude();
  end

  initial begin
    {rst_n, regWrite, regRead, en, dis, ret, ge} = '0;
    {regAddr, regWdata, mask, prio, modeVal} = '0;
    {reqIn, enIn, ackDelay} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 5; a++) begin
      rd(a == 4 ? 8'h10 : (a == 3 ? 8'hFF : 8'hDC + 8'(a)), d);
      chk(d, 8'h00, "reset or unmapped");
    end
    setMask(8'hFF);
    reqIn <= 18'h00001;
    enIn <= 18'h00001;
    settle();
    instr(0);
    settle();
    for (int j = 0; j < 2; j++) begin
      modeVal = j ? 8'h5D : 8'hE0;
      wr(8'hDE, modeVal);
      ge = modeVal[0];
      settle();
      rd(8'hDE, d);
      chk(d, modeVal, "mode");
    end
    wr(8'hDC, 8'hFF);
    rd(8'hDC, d);
    chk(d, 8'h01, "request read only");
    for (int it = 0; it < 512; it++) begin
      if (it % 8 == 0) setMask(8'(xs()));
      prio = 8'(it);
      wr(8'hFF, prio);
      instr((xs() % 4 == 0) ? 1 : 0);
      reqIn <= 18'(xs());
      enIn <= legal(18'(xs()));
      settle();
    end
    rd(8'hFF, d);
    chk(d, prio, "priority");
    setMask(8'hFF);
    rd(8'hDD, d);
    chk(d, 8'hFF, "mask");
    reqIn <= 18'h3FFFF;
    enIn <= legal(18'h3FFFF);
    for (int j = 0; j < 2; j++) begin
      instr(0);
      ackDelay <= j ? 4'h7 : 4'h1;
      n = 0;
      while (intAck !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk({7'h00, intAck}, 8'h01, "acknowledge");
      @(posedge clk);
      ackDelay <= 4'h0;
      ge = 1'b0;
      settle();
      chk({7'h00, inService}, 8'h01, "in service");
      rd(8'hDE, d);
      chk(d, modeVal & 8'hFE, "mode after acknowledge");
      instr(2);
      settle();
      chk({7'h00, inService}, 8'h00, "returned");
    end
    conclude();
  end
endmodule // tb
